// ---- core/pin_mode_config.sv ----
module pin_mode_config
   import pin_mode_pkg::*;
(
   input  wire logic                     core_clk,
   input  wire logic                     rst,
   input  wire logic [31:0]              address,
   input  wire logic                     read,
   input  wire logic                     write,
   input  wire logic [31:0]              writedata,
   input  wire logic [3:0]               byteenable,
   output logic      [31:0]              readdata,
   output logic                          waitrequest,
   input  wire logic [PIN_COUNT-1:0]     padIn,
   output logic      [PIN_COUNT-1:0]     padOut,
   output logic      [PIN_COUNT-1:0]     padOutEn,
   output logic      [PIN_COUNT-1:0]     pullUpEn,
   output logic      [PIN_COUNT-1:0]     pullDownEn,
   output logic      [PIN_COUNT-1:0]     analogEn,
   input  wire logic [FUNC_COUNT-1:0]    periphOut,
   output logic      [FUNC_COUNT-1:0]    funcIn
);

   //===========================================================================
   // Functions
   function automatic logic [PIN_COUNT-1:0] decodeAddr(input logic [31:0] addr);
      logic [PIN_COUNT-1:0] hit;
      hit = '0;
      for (int k = 0; k < PIN_COUNT; k++) begin
         hit[k] = (addr == REG_INDEX[k]);
      end
      return hit;
   endfunction

   // Returns {outputEnable, pullUp, pullDown} for one pin
   function automatic logic [2:0] padCtl(input pull_type pull, input logic adc);
      logic [2:0] ctl;
      ctl = 3'h0;
      if (!adc) begin // RQ3
         unique case (pull)
            PULL_NONE:   ctl = 3'h0; // RQ1
            PULL_UP:     ctl = 3'h2; // RQ1
            PULL_DOWN:   ctl = 3'h1; // RQ1
            PULL_OUTPUT: ctl = 3'h4; // RQ2
         endcase
      end
      return ctl;
   endfunction

   //===========================================================================
   // Mode registers
   logic     [PIN_COUNT-1:0]             driveMode;
   pull_type                             pullMode [PIN_COUNT];
   logic     [PIN_COUNT-1:0][FUNC_W-1:0] funcMode;

   bus_state_type                        busState;
   logic     [PIN_COUNT-1:0]             hitVec;
   logic     [PIN_COUNT-1:0]             wrHigh;
   logic     [PIN_COUNT-1:0]             wrLow;
   logic     [31:0]                      regWord [PIN_COUNT];
   logic     [31:0]                      next_readdata;
   logic                                 takeWrite;

   assign hitVec    = decodeAddr(address);
   // A write lands on the edge where the master sees waitrequest low
   assign takeWrite = (busState == BUS_ANSWER) && write;
   assign wrHigh    = {PIN_COUNT{takeWrite && byteenable[1]}} & hitVec;
   assign wrLow     = {PIN_COUNT{takeWrite && byteenable[0]}} & hitVec;

   genvar i;
   generate
      for (i = 0; i < PIN_COUNT; i++) begin : g_reg
         // Reserved bits are never stored, so they read as zero
         assign regWord[i] = {21'h000000, driveMode[i], pullMode[i],
                              2'h0, funcMode[i]}; // RQ6

         always_ff @(posedge core_clk) begin
            if (rst) begin
               driveMode[i] <= DRIVE_RESET; // RQ4
               pullMode[i]  <= PULL_RESET;  // RQ1
               funcMode[i]  <= FUNC_RESET;  // RQ6
            end else begin
               if (wrHigh[i]) begin
                  driveMode[i] <= writedata[DRIVE_BIT];                          // RQ4
                  pullMode[i]  <= pull_type'(writedata[PULL_MSB:PULL_LSB]);      // RQ1
               end
               if (wrLow[i]) begin
                  funcMode[i] <= writedata[FUNC_MSB:FUNC_LSB];
               end
            end
         end
      end
   endgenerate

   //===========================================================================
   // Read mux; an unmapped address reads zero
   always_comb begin
      next_readdata = DATA_ZERO;
      for (int k = 0; k < PIN_COUNT; k++) begin
         if (hitVec[k]) begin
            next_readdata = regWord[k];
         end
      end
   end

   //===========================================================================
   // Avalon slave: every access answers one cycle after it is seen.
   // The fixed latency costs a cycle but keeps waitrequest a clean flop.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         busState    <= BUS_IDLE;
         waitrequest <= 1'h1;
         readdata    <= DATA_ZERO;
      end else begin
         unique case (busState)
            BUS_IDLE: begin
               if (read || write) begin
                  busState    <= BUS_ANSWER;
                  waitrequest <= 1'h0;
                  readdata    <= read ? next_readdata : DATA_ZERO;
               end
            end
            BUS_ANSWER: begin
               busState    <= BUS_IDLE;
               waitrequest <= 1'h1;
            end
         endcase
      end
   end

   //===========================================================================
   // Pad control
   logic [PIN_COUNT-1:0] adcMode;
   logic [PIN_COUNT-1:0] drvVal;
   logic [2:0]           ctl [PIN_COUNT];
   logic [PIN_COUNT-1:0] next_outEn;
   logic [PIN_COUNT-1:0] next_padOut;

   generate
      for (i = 0; i < PIN_COUNT; i++) begin : g_pad
         assign adcMode[i]     = (funcMode[i] == FUNC_ADC);
         assign ctl[i]         = padCtl(pullMode[i], adcMode[i]);
         assign drvVal[i]      = periphOut[funcMode[i]];
         // Open drain only pulls low; a high level releases the pad
         assign next_outEn[i]  = ctl[i][2] && !(driveMode[i] && drvVal[i]); // RQ4
         assign next_padOut[i] = driveMode[i] ? 1'h0 : drvVal[i];            // RQ4
      end
   endgenerate

   always_ff @(posedge core_clk) begin
      if (rst) begin
         padOut     <= '0;
         padOutEn   <= '0;
         pullUpEn   <= '0;
         pullDownEn <= '1;
         analogEn   <= '0;
      end else begin
         padOut   <= next_padOut;
         padOutEn <= next_outEn;
         analogEn <= adcMode; // RQ3
         for (int k = 0; k < PIN_COUNT; k++) begin
            pullUpEn[k]   <= ctl[k][1];
            pullDownEn[k] <= ctl[k][0];
         end
      end
   end

   //===========================================================================
   // Input routing
   logic [PIN_COUNT-1:0] padLevel;

   pin_sync u_sync (
      .core_clk  (core_clk),
      .rst       (rst),
      .pinRaw    (padIn),
      .pinStable (padLevel)
   );

   input_router u_router (
      .core_clk (core_clk),
      .rst      (rst),
      .pinLevel (padLevel),
      .funcSel  (funcMode),
      .funcIn   (funcIn)
   );

   //===========================================================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence busRequest;
      (read || write) && waitrequest && busState == BUS_IDLE;
   endsequence

   sequence busAnswer;
      !waitrequest ##1 waitrequest;
   endsequence

   a_answer_timing: assert property (
      busRequest |=> busAnswer)
      else $error("bus access not answered in one cycle");

   a_reserved_zero: assert property ( // RQ6
      read && !waitrequest |-> readdata[31:11] == 21'h000000 && readdata[7:6] == 2'h0)
      else $error("reserved bits read nonzero");

   a_unmapped_zero: assert property ( // RQ6
      read && busState == BUS_IDLE && hitVec == '0 |=> readdata == DATA_ZERO)
      else $error("unmapped read returned nonzero data");

   a_idle_waits: assert property (
      !read && !write && busState == BUS_IDLE |=> waitrequest)
      else $error("waitrequest dropped with no access");

   a_answer_once: assert property (
      !waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");

   // Pads must come out of reset as pulled-down inputs, never driving
   a_pads_after_reset: assert property ( // RQ1
      $past(rst) |-> pullDownEn == '1 && pullUpEn == '0 && padOutEn == '0 && waitrequest)
      else $error("outputs wrong after reset");

   generate
      for (i = 0; i < PIN_COUNT; i++) begin : g_chk
         sequence regWrite;
            write && !waitrequest && address == REG_INDEX[i] && byteenable[1];
         endsequence

         a_write_lands: assert property ( // RQ4
            regWrite |=> driveMode[i] == $past(writedata[DRIVE_BIT])
                         && pullMode[i] == pull_type'($past(writedata[PULL_MSB:PULL_LSB])))
            else $error("mode write did not land");

         a_reset_values: assert property ( // RQ1
            $past(rst) |-> pullMode[i] == PULL_DOWN && !driveMode[i] && funcMode[i] == 6'h00)
            else $error("mode register reset value wrong");

         a_no_pull_input: assert property ( // RQ1
            pullMode[i] == PULL_NONE && !adcMode[i]
            |=> !pullUpEn[i] && !pullDownEn[i] && !padOutEn[i])
            else $error("plain input mode wrong");

         a_pull_up_input: assert property ( // RQ1
            pullMode[i] == PULL_UP && !adcMode[i]
            |=> pullUpEn[i] && !pullDownEn[i] && !padOutEn[i])
            else $error("pull-up input mode wrong");

         a_pull_down_input: assert property ( // RQ1
            pullMode[i] == PULL_DOWN && !adcMode[i]
            |=> !pullUpEn[i] && pullDownEn[i] && !padOutEn[i])
            else $error("pull-down input mode wrong");

         a_output_no_pull: assert property ( // RQ2
            pullMode[i] == PULL_OUTPUT && !adcMode[i] && !driveMode[i]
            |=> padOutEn[i] && !pullUpEn[i] && !pullDownEn[i] && padOut[i] == $past(drvVal[i]))
            else $error("output mode wrong");

         a_analog_ignores_pull: assert property ( // RQ3
            adcMode[i] |=> analogEn[i] && !pullUpEn[i] && !pullDownEn[i] && !padOutEn[i])
            else $error("pull field acted in analog mode");

         a_open_drain_drive: assert property ( // RQ4
            pullMode[i] == PULL_OUTPUT && !adcMode[i] && driveMode[i]
            |=> !padOut[i] && padOutEn[i] == !$past(drvVal[i]))
            else $error("open-drain drive wrong");

         a_func_write_lands: assert property ( // RQ6
            write && !waitrequest && address == REG_INDEX[i] && byteenable[0]
            |=> funcMode[i] == $past(writedata[FUNC_MSB:FUNC_LSB]))
            else $error("function write did not land");

         // A write without its lane enable must leave that field alone
         a_high_lane_hold: assert property ( // RQ6
            !(write && !waitrequest && address == REG_INDEX[i] && byteenable[1])
            |=> $stable(driveMode[i]) && $stable(pullMode[i]))
            else $error("drive or pull field changed without a write");

         a_low_lane_hold: assert property ( // RQ6
            !(write && !waitrequest && address == REG_INDEX[i] && byteenable[0])
            |=> $stable(funcMode[i]))
            else $error("function field changed without a write");

         a_read_returns: assert property ( // RQ6
            read && busState == BUS_IDLE && address == REG_INDEX[i]
            |=> readdata == $past(regWord[i]))
            else $error("read data does not match the register");

         a_analog_flag_off: assert property ( // RQ3
            !adcMode[i] |=> !analogEn[i])
            else $error("analog flag set for a digital function");

         a_push_pull_value: assert property ( // RQ4
            !driveMode[i] |=> padOut[i] == $past(drvVal[i]))
            else $error("push-pull drive value wrong");

         a_open_drain_low: assert property ( // RQ4
            driveMode[i] |=> !padOut[i])
            else $error("open-drain pad driven high");
      end
   endgenerate

endmodule

// ---- include/pin_mode_pkg.sv ----
//==============================================================================
// Contract
// (RQ1) Pull field 9:8: 00 plain input, 01 pull-up, 10 pull-down; resets to 10.
// (RQ2) Pull field 11 makes the pin an output with no resistor enabled.
// (RQ3) In analog converter mode the pull field has no effect on the pin.
// (RQ4) Bit 10 selects push-pull when 0, open-drain when 1; resets to 0.
// (RQ5) An input function on several pins follows the lowest index, port 0 first.
// (RQ6) Bits 15:11 and 7:6 read zero and ignore writes; function field resets zero.
package pin_mode_pkg;

   //===========================================================================
   // Sizes
   localparam int PIN_COUNT   = 7;
   localparam int FUNC_W      = 6;
   localparam int FUNC_COUNT  = 64;
   localparam int SYNC_STAGES = 3;

   //===========================================================================
   // Register indices, in pin order: port 0 pins 6 and 7, then port 1 pins 0 to 4.
   // The bus carries word addresses, so the index is the address itself.
   localparam logic [31:0] REG_INDEX [PIN_COUNT] = '{
      32'h5000302A, 32'h5000302C, 32'h5000302E, 32'h50003030,
      32'h50003032, 32'h50003034, 32'h50003036
   };

   //===========================================================================
   // Field layout and reset values
   localparam int DRIVE_BIT = 10;
   localparam int PULL_MSB  = 9;
   localparam int PULL_LSB  = 8;
   localparam int FUNC_MSB  = 5;
   localparam int FUNC_LSB  = 0;

   localparam logic              DRIVE_RESET = 1'h0;
   localparam logic [FUNC_W-1:0] FUNC_RESET  = 6'h00;
   localparam logic [31:0]       DATA_ZERO   = 32'h00000000;

   // Analog converter input function code; the full code list lives elsewhere
   localparam logic [FUNC_W-1:0] FUNC_ADC = 6'h0F;

   //===========================================================================
   // Types
   typedef enum logic [1:0] {
      PULL_NONE   = 2'h0,
      PULL_UP     = 2'h1,
      PULL_DOWN   = 2'h2,
      PULL_OUTPUT = 2'h3
   } pull_type;

   localparam pull_type PULL_RESET = PULL_DOWN;

   typedef enum logic {
      BUS_IDLE   = 1'h0,
      BUS_ANSWER = 1'h1
   } bus_state_type;

endpackage

// ---- core/pin_sync.sv ----
module pin_sync
   import pin_mode_pkg::*;
(
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   input  wire logic [PIN_COUNT-1:0] pinRaw,
   output logic      [PIN_COUNT-1:0] pinStable
);

   //===========================================================================
   // Three-stage synchroniser; a change counts once stages two and three agree
   logic [PIN_COUNT-1:0] stage [SYNC_STAGES];
   logic [PIN_COUNT-1:0] agree;

   // Stage one feeds only stage two, never the compare below
   assign agree = ~(stage[1] ^ stage[2]);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int s = 0; s < SYNC_STAGES; s++) begin
            stage[s] <= '0;
         end
         pinStable <= '0;
      end else begin
         stage[0]  <= pinRaw;
         stage[1]  <= stage[0];
         stage[2]  <= stage[1];
         pinStable <= (agree & stage[2]) | (~agree & pinStable);
      end
   end

endmodule

// ---- core/input_router.sv ----
module input_router
   import pin_mode_pkg::*;
(
   input  wire logic                                core_clk,
   input  wire logic                                rst,
   input  wire logic [PIN_COUNT-1:0]                pinLevel,
   input  wire logic [PIN_COUNT-1:0][FUNC_W-1:0]    funcSel,
   output logic      [FUNC_COUNT-1:0]               funcIn
);

   //===========================================================================
   // Priority selection per function
   logic [FUNC_COUNT-1:0] next_funcIn;

   genvar f;
   generate
      for (f = 0; f < FUNC_COUNT; f++) begin : g_func
         // Walk from the top down so the lowest index overwrites last
         always_comb begin
            next_funcIn[f] = 1'h0;
            for (int p = PIN_COUNT - 1; p >= 0; p--) begin
               if (funcSel[p] == FUNC_W'(f)) begin
                  next_funcIn[f] = pinLevel[p]; // RQ5
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk) begin
      if (rst) begin
         funcIn <= '0;
      end else begin
         funcIn <= next_funcIn;
      end
   end

   //===========================================================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_lowest_pin_wins: assert property ( // RQ5
      funcSel[0] == funcSel[1] |=> funcIn[$past(funcSel[0])] == $past(pinLevel[0]))
      else $error("shared input function not fed by lowest pin");

   a_port_zero_first: assert property ( // RQ5
      funcSel[1] == funcSel[2] && funcSel[0] != funcSel[1]
      |=> funcIn[$past(funcSel[1])] == $past(pinLevel[1]))
      else $error("port 0 pin lost precedence over port 1");

endmodule

// ---- sim/test_pin_mode_config.sv ----
module test_pin_mode_config
   import pin_mode_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   //===========================================================================
   // Design connections
   logic                  core_clk;
   logic                  rst;
   logic [31:0]           address;
   logic                  read;
   logic                  write;
   logic [31:0]           writedata;
   logic [3:0]            byteenable;
   logic [31:0]           readdata;
   logic                  waitrequest;
   logic [PIN_COUNT-1:0]  padIn;
   logic [PIN_COUNT-1:0]  padOut;
   logic [PIN_COUNT-1:0]  padOutEn;
   logic [PIN_COUNT-1:0]  pullUpEn;
   logic [PIN_COUNT-1:0]  pullDownEn;
   logic [PIN_COUNT-1:0]  analogEn;
   logic [FUNC_COUNT-1:0] periphOut;
   logic [FUNC_COUNT-1:0] funcIn;
   int                    badCount;
   int                    testsRun;
   int                    cycles;
   int                    seed;
   logic [15:0]           modelReg [PIN_COUNT];

   pin_mode_config pin_mode_config_i (
      .core_clk(core_clk), .rst(rst), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .padIn(padIn), .padOut(padOut), .padOutEn(padOutEn),
      .pullUpEn(pullUpEn), .pullDownEn(pullDownEn), .analogEn(analogEn),
      .periphOut(periphOut), .funcIn(funcIn)
   );

   //===========================================================================
   // Clock and hang guard
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // Whole run is well under a thousand cycles; the ceiling leaves ample slack
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         badCount = badCount + 1;
         summarize();
      end
   end

   //===========================================================================
   // Reporting
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      testsRun = testsRun + 1;
      if (got !== exp) begin
         badCount = badCount + 1;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", testsRun, badCount);
      if (badCount == 0 && testsRun > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   //===========================================================================
   // Bus master: holds the request until waitrequest is sampled low
   task automatic busCycle(input logic [31:0] addr, input logic isWr, input logic [31:0] data,
                           input logic [3:0] be, output logic [31:0] rdata);
      int n;
      @(posedge core_clk);
      address    <= addr;
      writedata  <= data;
      byteenable <= be;
      write      <= isWr;
      read       <= ~isWr;
      n = 0;
      do begin
         @(posedge core_clk);
         n = n + 1;
      end while (waitrequest !== 1'b0 && n < 50);
      if (n >= 50) check(32'h1, 32'h0, "bus answer missing");
      rdata = readdata;
      write <= 1'b0;
      read  <= 1'b0;
   endtask

   task automatic regWrite(input int idx, input logic [15:0] data, input logic [3:0] be);
      logic [31:0] r;
      busCycle(REG_INDEX[idx], 1'b1, {16'h0000, data}, be, r);
      if (be[0]) modelReg[idx][5:0] = data[5:0];
      if (be[1]) modelReg[idx][10:8] = data[10:8];
   endtask

   task automatic regRead(input logic [31:0] addr, input logic [31:0] exp);
      logic [31:0] r;
      busCycle(addr, 1'b0, 32'h00000000, 4'hF, r);
      check(r, exp, "register read");
   endtask

   //===========================================================================
   // Pad model: pull field, drive bit, analog override
   task automatic checkPads();
      logic [5:0] f;
      logic [4:0] exp;
      repeat (3) @(posedge core_clk);
      #1;
      for (int i = 0; i < PIN_COUNT; i++) begin
         f = modelReg[i][5:0];
         exp = 5'h00;
         if (f == FUNC_ADC) exp = 5'h10;
         else if (modelReg[i][9:8] == 2'h1) exp = 5'h08;
         else if (modelReg[i][9:8] == 2'h2) exp = 5'h04;
         else if (modelReg[i][9:8] == 2'h3) exp[1] = !(modelReg[i][10] && periphOut[f]);
         // The drive value reaches the pad flop in every mode; open drain forces it low
         exp[0] = !modelReg[i][10] && periphOut[f];
         check({27'h0, analogEn[i], pullUpEn[i], pullDownEn[i], padOutEn[i], padOut[i]},
               {27'h0, exp}, "pad controls");
      end
   endtask

   //===========================================================================
   // Main sequence
   initial begin
      logic [15:0] d;
      int          k;
      logic        e;
      badCount = 0;
      testsRun = 0;
      cycles = 0;
      seed = 32'h4f016724;
      rst = 1'b1;
      address = 32'h00000000;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h00000000;
      byteenable = 4'h0;
      padIn = '0;
      periphOut = '0;
      for (int i = 0; i < PIN_COUNT; i++) modelReg[i] = 16'h0200;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      check({25'h0, pullDownEn}, 32'h0000007F, "pull-down during reset");
      checkPads();
      for (int i = 0; i < PIN_COUNT; i++) regRead(REG_INDEX[i], 32'h00000200);
      regWrite(0, 16'hFFFF, 4'h0);
      regRead(REG_INDEX[0], 32'h00000200);
      regRead(32'h50003038, 32'h00000000);
      // Every pull and drive combination, with changing peripheral outputs
      for (int p = 0; p < 8; p++) begin
         periphOut <= {$random(seed), $random(seed)};
         for (int i = 0; i < PIN_COUNT; i++) regWrite(i, {5'h00, p[2:0], 2'h0, 6'(i + 1)}, 4'h3);
         checkPads();
      end
      // Analog mode hides the pull field but keeps it readable
      for (int p = 0; p < 4; p++) begin
         regWrite(p, {6'h00, p[1:0], 2'h0, FUNC_ADC}, 4'h3);
         checkPads();
         regRead(REG_INDEX[p], {16'h0000, modelReg[p]});
      end
      // Random data and lanes; reserved bits must read back zero
      for (int n = 0; n < 24; n++) begin
         k = {$random(seed)} % PIN_COUNT;
         d = 16'($random(seed));
         regWrite(k, d, 4'($random(seed)));
         regRead(REG_INDEX[k], {16'h0000, modelReg[k]});
      end
      checkPads();
      // Reset again mid-run; every register must fall back
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      for (int i = 0; i < PIN_COUNT; i++) modelReg[i] = 16'h0200;
      checkPads();
      for (int i = 0; i < PIN_COUNT; i++) regRead(REG_INDEX[i], 32'h00000200);
      // Shared input function on pins 1, 3 and 6; pin 1 must win
      for (int i = 0; i < PIN_COUNT; i++) begin
         regWrite(i, {10'h000, (i == 1 || i == 3 || i == 6) ? 6'h05 : 6'(i + 20)}, 4'h3);
      end
      for (int n = 0; n < 12; n++) begin
         padIn <= 7'($random(seed));
         repeat (8) @(posedge core_clk);
         #1;
         check({31'h0, funcIn[5]}, {31'h0, padIn[1]}, "shared function source");
         for (int i = 0; i < PIN_COUNT; i++) begin
            e = (i == 1 || i == 3 || i == 6) ? 1'b0 : 1'b1;
            if (e) check({31'h0, funcIn[i + 20]}, {31'h0, padIn[i]}, "routed input");
         end
      end
      summarize();
   end
endmodule
